// ===== design/txe_core.sv
// Execution slice for table reads and writes, test-and-skip and two XOR forms.
// Assumes a data register file and program memory that answer one clock
// after their read strobes, and a fetch unit that waits on instr_ready.
//
// Overview of operation
// [RULE_01] Table write is fourteen fixed bits plus a mode: none, post-inc, post-dec, pre-inc.
// [RULE_02] Post modes store then adjust the pointer; pre-increment adjusts before storing.
// [RULE_03] Pointer bits two to zero pick one of eight holding registers.
// [RULE_04] Holding registers stage bytes; a table write never alters program memory.
// [RULE_05] The table pointer is 21 bits, a bytewise two-megabyte range.
// [RULE_06] Pointer bit zero picks low byte (0) or high byte (1) of a word.
// [RULE_07] Test-and-skip decodes from 0110 011a with a register address; flags untouched.
// [RULE_08] A zero register discards the fetched next instruction; one no-op cycle follows.
// [RULE_09] A skipped two-word instruction costs two no-op cycles, three in total.
// [RULE_10] Access bit 0 selects the access bank; 1 uses the bank select register.
// [RULE_11] XOR-literal combines working register with the low opcode byte into W.
// [RULE_12] Both XOR forms update only negative and zero flags.
// [RULE_13] XOR-register destination bit 0 writes W, 1 writes the register.
// [RULE_14] Register ops decode in Q1, read in Q2, process in Q3, write in Q4.
// [RULE_15] Table read copies the memory byte at the pointer into the latch.
`timescale 1ns/100ps
module txe_core
    import txe_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_next_two_word,
    output logic             instr_ready,
    output logic             instr_done,
    output logic             discard_next,
    output logic             data_rd,
    output logic             data_wr,
    output logic [11:0]      data_addr,
    output logic [7:0]       data_wdata,
    input  wire logic [7:0]  data_rdata,
    output logic             pmem_rd,
    output logic [19:0]      pmem_word_addr,
    input  wire logic [15:0] pmem_rdata,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    txe_regs_t r;
    txe_regs_t next_r;

    logic       is_trd;
    logic       is_twr;
    logic       is_tst;
    logic       is_xorl;
    logic       is_xorr;
    logic [1:0] tmode;
    logic [11:0] f_addr;
    logic [7:0] rd_byte;
    logic [7:0] xres;

    // Opcode classes; anything else runs as a one-cycle no-op.
    assign is_trd   = (r.ir[15:2] == OP_TRD_HI); // RULE_15
    assign is_twr   = (r.ir[15:2] == OP_TWR_HI); // RULE_01
    assign is_tst   = (r.ir[15:9] == OP_TSTSZ_HI); // RULE_07
    assign is_xorl  = (r.ir[15:8] == OP_XORL_HI);
    assign is_xorr  = (r.ir[15:10] == OP_XORR_HI);
    assign tmode    = r.ir[1:0];

    // Register address: the access bank splits its low half to bank 0 and
    // its high half to the top bank, so special registers stay reachable.
    always_comb begin
        if (!r.ir[8]) begin
            f_addr = (r.ir[7:0] < ACCESS_SPLIT) ? {ACCESS_LO_BANK, r.ir[7:0]} // RULE_10
                                                : {ACCESS_HI_BANK, r.ir[7:0]};
        end else begin
            f_addr = {r.bank, r.ir[7:0]}; // RULE_10
        end
    end

    // Byte of the returned program memory word picked by pointer bit zero.
    assign rd_byte = r.tptr[0] ? pmem_rdata[15:8] : pmem_rdata[7:0]; // RULE_06

    // XOR against the literal or against the register just read.
    assign xres = r.wreg ^ (is_xorl ? r.ir[7:0] : data_rdata); // RULE_11 RULE_13

    assign instr_ready    = (r.st == TXE_IDLE);
    assign instr_done     = r.done;
    assign discard_next   = r.discard;
    assign data_rd        = r.d_rd;
    assign data_wr        = r.d_wr;
    assign data_addr      = r.d_addr;
    assign data_wdata     = r.d_wdata;
    assign pmem_rd        = r.pm_rd;
    assign pmem_word_addr = r.pm_addr;
    assign reg_rdata      = r.rdata;

    // Next state. Software writes are applied first so that a hardware
    // update in the same cycle overrides them and is never lost.
    always_comb begin
        next_r         = r;
        next_r.done    = 1'b0;
        next_r.discard = 1'b0;
        next_r.d_rd    = 1'b0;
        next_r.d_wr    = 1'b0;
        next_r.pm_rd   = 1'b0;
        next_r.rdata   = 32'h0000_0000;

        // Register bus reads answer one clock later; unmapped reads give zero.
        if (reg_rd) begin
            unique case (reg_addr)
                RA_TPTR:   next_r.rdata = {11'h000, r.tptr};
                RA_TLAT:   next_r.rdata = {24'h00_0000, r.tlat};
                RA_WREG:   next_r.rdata = {24'h00_0000, r.wreg};
                RA_BANK:   next_r.rdata = {28'h000_0000, r.bank};
                RA_STATUS: next_r.rdata = {24'h00_0000, r.status};
                RA_CORE:   next_r.rdata = {27'h000_0000, r.two_word, r.phase, r.st == TXE_IDLE,
                                           r.st != TXE_IDLE};
                default: begin
                    if (reg_addr[7:5] == RA_HOLD_HI && reg_addr[1:0] == 2'b00) begin
                        next_r.rdata = {24'h00_0000, r.hold[reg_addr[4:2]]};
                    end
                end
            endcase
        end

        // Register bus writes.
        if (reg_wr) begin
            unique case (reg_addr)
                RA_TPTR:   next_r.tptr = reg_wdata[20:0]; // RULE_05
                RA_TLAT:   next_r.tlat = reg_wdata[7:0];
                RA_WREG:   next_r.wreg = reg_wdata[7:0];
                RA_BANK:   next_r.bank = reg_wdata[3:0];
                RA_STATUS: next_r.status = reg_wdata[7:0];
                default: begin
                    if (reg_addr[7:5] == RA_HOLD_HI && reg_addr[1:0] == 2'b00) begin
                        next_r.hold[reg_addr[4:2]] = reg_wdata[7:0];
                    end
                end
            endcase
        end

        // Quarter phase counter runs while an instruction is in flight.
        if (r.st != TXE_IDLE) begin
            next_r.phase = r.phase + 2'd1;
        end

        unique case (r.st)
            TXE_IDLE: begin
                next_r.phase = Q1;
                if (instr_valid) begin
                    next_r.ir       = instr_word;
                    next_r.two_word = instr_next_two_word;
                    next_r.st       = TXE_EXEC;
                end
            end

            TXE_EXEC: begin
                unique case (r.phase)
                    // Q1 decode; the read strobe is raised for Q2.
                    Q1: begin
                        if (is_tst || is_xorr) begin
                            next_r.d_rd   = 1'b1; // RULE_14
                            next_r.d_addr = f_addr;
                        end
                    end
                    // Q2 the register file is read.
                    Q2: begin
                        next_r.d_addr = f_addr;
                    end
                    // Q3 the operand is processed; writes are staged for Q4.
                    Q3: begin
                        next_r.opnd = is_xorl ? r.ir[7:0] : data_rdata;
                        next_r.res  = xres;
                        next_r.skip = is_tst && (data_rdata == 8'h00); // RULE_08
                        if (is_xorr && r.ir[9]) begin
                            next_r.d_wr    = 1'b1; // RULE_13 RULE_14
                            next_r.d_addr  = f_addr;
                            next_r.d_wdata = xres;
                        end
                    end
                    // Q4 the destination is written and the next cycle chosen.
                    Q4: begin
                        if (is_xorl || is_xorr) begin
                            if (is_xorl || !r.ir[9]) begin
                                next_r.wreg = r.res; // RULE_11 RULE_13
                            end
                            next_r.status[FLAG_Z] = (r.res == 8'h00); // RULE_12
                            next_r.status[FLAG_N] = r.res[7]; // RULE_12
                        end
                        if ((is_trd || is_twr) && tmode == TM_PRE_INC) begin
                            next_r.tptr = r.tptr + PTR_ONE; // RULE_02
                        end
                        if (is_trd || is_twr) begin
                            next_r.st = TXE_TBL2;
                        end else if (r.skip) begin
                            next_r.discard = 1'b1; // RULE_08
                            next_r.st      = TXE_NOP1;
                        end else begin
                            next_r.done = 1'b1;
                            next_r.st   = TXE_IDLE;
                        end
                    end
                    default: ;
                endcase
            end

            // Second table cycle: memory or latch access, then store and adjust.
            TXE_TBL2: begin
                unique case (r.phase)
                    Q1: begin
                        if (is_trd) begin
                            next_r.pm_rd   = 1'b1; // RULE_15
                            next_r.pm_addr = r.tptr[20:1];
                        end
                    end
                    Q2: ;
                    Q3: begin
                        next_r.opnd = is_trd ? rd_byte : r.tlat; // RULE_06
                    end
                    Q4: begin
                        // Holding bytes are only staged; programming is elsewhere.
                        if (is_twr) begin
                            next_r.hold[r.tptr[2:0]] = r.opnd; // RULE_03 RULE_04
                        end else begin
                            next_r.tlat = r.opnd; // RULE_15
                        end
                        unique case (tmode)
                            TM_POST_INC: next_r.tptr = r.tptr + PTR_ONE; // RULE_02
                            TM_POST_DEC: next_r.tptr = r.tptr - PTR_ONE; // RULE_02
                            default: ;
                        endcase
                        next_r.done = 1'b1;
                        next_r.st   = TXE_IDLE;
                    end
                    default: ;
                endcase
            end

            // Skip cycles; a two-word follower needs a second empty cycle.
            TXE_NOP1: begin
                if (r.phase == Q4) begin
                    if (r.two_word) begin
                        next_r.st = TXE_NOP2; // RULE_09
                    end else begin
                        next_r.done = 1'b1;
                        next_r.st   = TXE_IDLE;
                    end
                end
            end

            TXE_NOP2: begin
                if (r.phase == Q4) begin
                    next_r.done = 1'b1; // RULE_09
                    next_r.st   = TXE_IDLE;
                end
            end

            default: begin
                next_r.st = TXE_IDLE;
            end
        endcase
    end

    // State register; everything resets to constants.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.st     <= TXE_IDLE;
            r.status <= STATUS_RST;
        end else begin
            r <= next_r;
        end
    end
endmodule

// ===== design/txe_pkg.sv
// Package for the table access, test-skip and exclusive-OR execution slice.
// Assumes one 100 MHz clock with four quarter phases per instruction cycle.
package txe_pkg;
    // Instruction cycle quarter phases, one clock each.
    localparam logic [1:0] Q1 = 2'd0;
    localparam logic [1:0] Q2 = 2'd1;
    localparam logic [1:0] Q3 = 2'd2;
    localparam logic [1:0] Q4 = 2'd3;

    // Opcode patterns and field widths.
    localparam logic [13:0] OP_TRD_HI   = 14'h0002;
    localparam logic [13:0] OP_TWR_HI   = 14'h0003;
    localparam logic [6:0]  OP_TSTSZ_HI = 7'h33;
    localparam logic [7:0]  OP_XORL_HI  = 8'h0A;
    localparam logic [5:0]  OP_XORR_HI  = 6'h06;

    // Table pointer adjust modes.
    localparam logic [1:0] TM_NONE = 2'd0;
    localparam logic [1:0] TM_POST_INC = 2'd1;
    localparam logic [1:0] TM_POST_DEC = 2'd2;
    localparam logic [1:0] TM_PRE_INC = 2'd3;

    localparam int          PTR_W       = 21;
    localparam logic [20:0] PTR_ONE     = 21'h00_0001;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

    // Status register flag positions and reset value.
    localparam int         FLAG_Z = 2;
    localparam int         FLAG_N = 4;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Register bus byte offsets.
    localparam logic [7:0] RA_TPTR   = 8'h00;
    localparam logic [7:0] RA_TLAT   = 8'h04;
    localparam logic [7:0] RA_WREG   = 8'h08;
    localparam logic [7:0] RA_BANK   = 8'h0C;
    localparam logic [7:0] RA_STATUS = 8'h10;
    localparam logic [7:0] RA_CORE   = 8'h14;
    localparam logic [7:0] RA_HOLD   = 8'h20;
    localparam logic [2:0] RA_HOLD_HI = 3'b001;

    typedef enum logic [2:0] {
        TXE_IDLE = 3'b000,
        TXE_EXEC = 3'b001,
        TXE_TBL2 = 3'b010,
        TXE_NOP1 = 3'b011,
        TXE_NOP2 = 3'b100
    } txe_state_t;

    // Whole state of the execution slice.
    typedef struct packed {
        txe_state_t      st;
        logic [1:0]      phase;
        logic [15:0]     ir;
        logic            two_word;
        logic [20:0]     tptr;
        logic [7:0]      tlat;
        logic [7:0]      wreg;
        logic [3:0]      bank;
        logic [7:0]      status;
        logic [7:0][7:0] hold;
        logic [7:0]      opnd;
        logic [7:0]      res;
        logic            skip;
        logic [31:0]     rdata;
        logic            done;
        logic            discard;
        logic            d_rd;
        logic            d_wr;
        logic [11:0]     d_addr;
        logic [7:0]      d_wdata;
        logic            pm_rd;
        logic [19:0]     pm_addr;
    } txe_regs_t;
endpackage

// ===== verif/txe_assertions.sv
// Port-level checks for the table, skip and exclusive-OR execution slice.
// Assumes it is bound to txe_core, with one clock and an active-low reset.
`timescale 1ns/100ps
module txe_checker
    import txe_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        instr_next_two_word,
    input wire logic        instr_ready,
    input wire logic        instr_done,
    input wire logic        discard_next,
    input wire logic        data_rd,
    input wire logic        data_wr,
    input wire logic [11:0] data_addr,
    input wire logic [7:0]  data_rdata,
    input wire logic        pmem_rd
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Accepted instruction, split by opcode family.
    logic acc, is_xl, is_xr, is_ts, is_tw, is_tr;
    assign acc   = instr_valid && instr_ready;
    assign is_xl = acc && (instr_word[15:8] == OP_XORL_HI);
    assign is_xr = acc && (instr_word[15:10] == OP_XORR_HI);
    assign is_ts = acc && (instr_word[15:9] == OP_TSTSZ_HI);
    assign is_tw = acc && (instr_word[15:2] == OP_TWR_HI);
    assign is_tr = acc && (instr_word[15:2] == OP_TRD_HI);

    // The destination bit is captured at acceptance, since the word moves on.
    property p_xr;
        logic d;
        (is_xr, d = instr_word[9]) |-> ##2 data_rd ##2 (data_wr == d) ##1 instr_done;
    endproperty
    property p_bank;
        logic [7:0] f;
        ((is_xr || is_ts) && !instr_word[8], f = instr_word[7:0]) |->
            ##2 (data_addr == {(f[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), f});
    endproperty
    property p_skip(logic two);
        logic tw;
        (is_ts, tw = instr_next_two_word) ##3 (data_rdata == 8'h00 && tw == two) |->
            ##2 discard_next ##4 (instr_done != two) ##4 (instr_done || !two);
    endproperty

    a_busy_four_cycles: assert property (acc |=> !instr_ready [*4])
        else $error("ready came back before the fourth quarter");
    a_lit_xor_no_read: assert property (is_xl |=> !data_rd [*4] ##1 instr_done)
        else $error("literal xor read the register file or ended late");
    a_reg_xor_phases: assert property (p_xr)
        else $error("register xor read or write out of place");
    a_access_bank: assert property (p_bank)
        else $error("access bank address wrong");
    a_skip_one_word: assert property (p_skip(1'b0))
        else $error("zero skip did not discard and end after two cycles");
    a_skip_two_word: assert property (p_skip(1'b1))
        else $error("zero skip over two words did not take three cycles");
    a_no_skip_nonzero: assert property (is_ts ##3 (data_rdata != 8'h00) |->
        ##2 (instr_done && !discard_next))
        else $error("nonzero register caused a skip");
    a_table_write_op_no_pmem: assert property (is_tw |=> !pmem_rd [*8] ##1 instr_done)
        else $error("table write touched program memory");
    a_table_read_op_fetch: assert property (is_tr |-> ##6 pmem_rd ##3 instr_done)
        else $error("table read fetch or finish out of place");

    // Main scenarios reached.
    c_skip_taken: cover property (is_ts ##3 (data_rdata == 8'h00));
    c_xor_reg: cover property (is_xr);
    c_table_write: cover property (is_tw);
endmodule

bind txe_core txe_checker chk_u (.*);

// ===== verif/txe_mem_model.sv
// Register file and program memory standing behind the execution slice.
// Assumes read strobes are answered one clock later; the bench preloads rf.
`timescale 1ns/100ps
module txe_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        data_rd,
    input  wire logic        data_wr,
    input  wire logic [11:0] data_addr,
    input  wire logic [7:0]  data_wdata,
    output logic      [7:0]  data_rdata,
    input  wire logic        pmem_rd,
    input  wire logic [19:0] pmem_word_addr,
    output logic      [15:0] pmem_rdata
);
    logic [7:0] rf [4096];

    // Answers stand one cycle only; otherwise the inverse of the last value
    // shows, so a late sample by the slice cannot pass by chance.
    always @(posedge sys_clk) begin
        if (data_wr)
            rf[data_addr] <= data_wdata;
        data_rdata <= data_rd ? rf[data_addr] : ~data_rdata;
        pmem_rdata <= pmem_rd ? {pmem_word_addr[7:0] ^ 8'hC3, pmem_word_addr[15:8]}
                              : ~pmem_rdata;
    end

    // Known levels before the first answer.
    initial begin
        data_rdata = 8'h00;
        pmem_rdata = 16'h0000;
    end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the execution slice with random operands.
// Assumes the package constants and the partner model in txe_mem_model.
`timescale 1ns/100ps
module tb_top import txe_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        instr_valid, instr_next_two_word, instr_ready, instr_done, discard_next;
    logic        data_rd, data_wr, pmem_rd, reg_wr, reg_rd;
    logic [15:0] instr_word, pmem_rdata;
    logic [11:0] data_addr, ad;
    logic [7:0]  data_wdata, data_rdata, reg_addr, w, st, f, k, v;
    logic [19:0] pmem_word_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [20:0] p, q;
    logic [3:0]  b;
    int          err_count, n_tests, cyc;
    logic [7:0]  rst_list [7] = '{RA_TPTR, RA_TLAT, RA_WREG, RA_BANK, RA_STATUS, RA_HOLD, 8'h18};

    txe_core      dut_u (.*);
    txe_mem_model mem_u (.*);

    // Free-running 100 MHz clock.
    initial forever #5 sys_clk = ~sys_clk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(string name, logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(name, reg_rdata, e);
    endtask
    // Offers one instruction and returns the cycle in which done was seen.
    task automatic exec(logic [15:0] op, logic two, output int n);
        @(posedge sys_clk);
        instr_valid         <= 1'b1;
        instr_word          <= op;
        instr_next_two_word <= two;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        for (n = 1; n < 20; n++) begin
            @(posedge sys_clk);
            #1;
            if (instr_done === 1'b1)
                break;
        end
        if (n == 20) begin
            err_count++;
            final_report();
        end
    endtask
    function automatic logic [7:0] flags(logic [7:0] s, logic [7:0] r);
        flags         = s;
        flags[FLAG_Z] = (r == 8'h00);
        flags[FLAG_N] = r[7];
    endfunction
    function automatic logic [11:0] eff(logic a, logic [7:0] fa, logic [3:0] bk);
        eff = a ? {bk, fa} : {(fa[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), fa};
    endfunction
    function automatic logic [20:0] adj(logic [1:0] m, logic [20:0] pt);
        case (m)
            TM_NONE:     adj = pt;
            TM_POST_DEC: adj = pt - PTR_ONE;
            default:     adj = pt + PTR_ONE;
        endcase
    endfunction

    // Main sequence: reset values, then each instruction family.
    initial begin
        {instr_valid, instr_next_two_word, reg_wr, reg_rd} = 4'h0;
        {instr_word, reg_addr, reg_wdata} = '0;
        err_count = 0;
        n_tests   = 0;
        v = 8'($urandom(32'h0000_24cb));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(8'h18, 32'hFFFF_FFFF);
        foreach (rst_list[j])
            rd("reset value", rst_list[j], 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            w  = 8'($urandom);
            st = 8'($urandom);
            k  = (i == 0) ? w : 8'($urandom);
            wr(RA_WREG, {24'h00_0000, w});
            wr(RA_STATUS, {24'h00_0000, st});
            exec({OP_XORL_HI, k}, 1'b0, cyc);
            check("lit xor cycles", cyc, 4);
            rd("lit xor w", RA_WREG, w ^ k);
            rd("lit xor status", RA_STATUS, flags(st, w ^ k));
        end
        for (int i = 0; i < 16; i++) begin
            {w, st, f, v} = $urandom;
            b = 4'($urandom);
            if (i inside {4, 5})
                f = (i == 4) ? 8'h7F : 8'h80;
            if (i == 1)
                v = w;
            ad = eff(i[1], f, b);
            mem_u.rf[ad] = v;
            wr(RA_WREG, {24'h00_0000, w});
            wr(RA_STATUS, {24'h00_0000, st});
            wr(RA_BANK, {28'h000_0000, b});
            exec({OP_XORR_HI, i[0], i[1], f}, 1'b0, cyc);
            check("reg xor cycles", cyc, 4);
            rd("reg xor w", RA_WREG, i[0] ? w : w ^ v);
            check("reg xor f", mem_u.rf[ad], i[0] ? v ^ w : v);
            rd("reg xor status", RA_STATUS, flags(st, w ^ v));
        end
        for (int i = 0; i < 8; i++) begin
            {f, st} = 16'($urandom);
            b  = 4'($urandom);
            ad = eff(i[2], f, b);
            mem_u.rf[ad] = i[0] ? (8'($urandom) | 8'h01) : 8'h00;
            wr(RA_STATUS, {24'h00_0000, st});
            wr(RA_BANK, {28'h000_0000, b});
            exec({OP_TSTSZ_HI, i[2], f}, i[1], cyc);
            check("skip cycles", cyc, i[0] ? 4 : (i[1] ? 12 : 8));
            rd("skip status", RA_STATUS, st);
        end
        for (int i = 0; i < 16; i++) begin
            p = i[2] ? ((i[1:0] == TM_POST_DEC) ? 21'h00_0000 : 21'h1F_FFFF) : 21'($urandom);
            v = 8'($urandom);
            q = (i[1:0] == TM_PRE_INC) ? p + PTR_ONE : p;
            wr(RA_TPTR, {11'h000, p});
            wr(RA_TLAT, {24'h00_0000, v});
            exec({i[3] ? OP_TRD_HI : OP_TWR_HI, i[1:0]}, 1'b0, cyc);
            check("table cycles", cyc, 8);
            rd("table ptr", RA_TPTR, {11'h000, adj(i[1:0], p)});
            if (i[3])
                rd("table read latch", RA_TLAT, q[0] ? q[8:1] ^ 8'hC3 : q[16:9]);
            else
                rd("table write hold", RA_HOLD + {q[2:0], 2'b00}, v);
        end
        // A second reset in mid-run must clear the working register again.
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd("wreg after reset", RA_WREG, 32'h0000_0000);
        final_report();
    end
endmodule
